/* File: src/comparator_sr_latch_ctrl.v */
// comparator set/reset latch, output routing and second comparator control register
`timescale 1ns/1ps
`include "comparator_latch_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - The block holds exactly one set/reset storage element and output selectors for the port pins.
// - Comparator outputs can set or reset the storage element as they change.
// - Software control bits can clear the element regardless of the comparator outputs, and set it while comparator two output is low.
// - Selectors pass either the latch outputs or the raw comparator outputs, per the latch configuration.
// - The element changes state on the rising edge of the system clock, without any timer clock edge.
// - Set and reset act when high; a low level on either has no effect.
// - Set is the OR of the first comparator output and a software set pulse.
// - Reset is the OR of the second comparator output and a software reset pulse.
// - With set and reset both high the element goes to reset.
// - The set and reset pulse bits clear themselves, so one write of a one does the whole operation.
// - Bit 5 set routes the programmable reference to comparator one, clear routes the fixed reference.
// - Bit 4 clear routes the fixed reference to comparator two, set routes the programmable reference.
// - Two read-only bits mirror both comparator outputs live, and reading them has no side effect.
// - Clearing the gate source bit makes the timer gate follow comparator two output.
// - With sync enabled, comparator two output is captured on the falling edge of the prescaled timer clock.
module comparator_sr_latch_ctrl (
	input wire clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire first_comparator_output,
	input wire second_comparator_output,
	input wire timer_clock,
	output reg first_port_out,
	output reg second_port_out,
	output reg first_reference_input,
	output reg second_reference_input,
	output reg timer_gate_from_comparator,
	output reg synchronized_second_output
);
	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] comparator_two_control_second;
	reg [7:0] latch_control_register;
	reg software_set_pulse;
	reg software_reset_pulse;
	reg timer_clock_d;
	reg next_sync_out;
	wire latch_q;
	wire sel_first;
	wire sel_second;
	wire bus_req;
	wire wr_lane0;
	wire set_in;
	wire reset_in;
	wire timer_fall;
	wire [7:0] ctrl2_read;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];

	////////////////////////////////////////////////////////////////////////////////
	// wishbone slave: one-cycle wait, ack one cycle
	always @(posedge clk) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// writable bits only; unimplemented positions stay zero
	always @(posedge clk) begin
		if (!nrst) begin
			comparator_two_control_second <= `CTRL2_RESET;
			latch_control_register <= `LATCH_CTRL_RESET;
		end else if (wr_lane0) begin
			if (wb_adr_i == `ADDR_COMPARATOR_TWO_CONTROL_SECOND) begin
				comparator_two_control_second <= wb_dat_i[7:0] & `CTRL2_WRITE_MASK;
			end else if (wb_adr_i == `ADDR_LATCH_CONTROL_REGISTER) begin
				latch_control_register <= wb_dat_i[7:0] & `LATCH_CTRL_WRITE_MASK;
			end
		end
	end

	// pulse bits live one cycle then clear; no hold means no stuck latch force
	always @(posedge clk) begin
		if (!nrst) begin
			software_set_pulse <= 1'b0;
			software_reset_pulse <= 1'b0;
		end else begin
			software_set_pulse <= wr_lane0 && (wb_adr_i == `ADDR_LATCH_CONTROL_REGISTER) &&
				wb_dat_i[`BIT_SOFTWARE_SET_PULSE];
			software_reset_pulse <= wr_lane0 && (wb_adr_i == `ADDR_LATCH_CONTROL_REGISTER) &&
				wb_dat_i[`BIT_SOFTWARE_RESET_PULSE];
		end
	end

	// mirrors are live; reading has no side effect at all
	assign ctrl2_read = {first_comparator_output, second_comparator_output,
		comparator_two_control_second[5:0]};

	// read mux, unmapped reads return zero
	always @(posedge clk) begin
		if (!nrst) begin
			wb_dat_o <= 32'h0;
		end else if (bus_req && !wb_we_i) begin
			if (wb_adr_i == `ADDR_COMPARATOR_TWO_CONTROL_SECOND) begin
				wb_dat_o <= {24'h0, ctrl2_read};
			end else if (wb_adr_i == `ADDR_LATCH_CONTROL_REGISTER) begin
				wb_dat_o <= {24'h0, latch_control_register}; // pulse bits read zero
			end else if (wb_adr_i == `ADDR_LATCH_STATUS) begin
				wb_dat_o <= {31'h0, latch_q};
			end else begin
				wb_dat_o <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// latch core
	assign set_in = first_comparator_output | software_set_pulse;
	assign reset_in = second_comparator_output | software_reset_pulse;

	// single storage element, no timer clock involved
	sr_storage u_storage (
		.clk(clk),
		.nrst(nrst),
		.set_in(set_in),
		.reset_in(reset_in),
		.q(latch_q)
	);

	output_select u_select (
		.config_sel({latch_control_register[`BIT_LATCH_CONFIG_HI], latch_control_register[`BIT_LATCH_CONFIG_LO]}),
		.first_comparator_output(first_comparator_output),
		.second_comparator_output(second_comparator_output),
		.latch_q(latch_q),
		.first_port_out(sel_first),
		.second_port_out(sel_second)
	);

	////////////////////////////////////////////////////////////////////////////////
	// timer clock falling edge, timer clock treated as synchronous input
	assign timer_fall = timer_clock_d & ~timer_clock;

	always @* begin
		next_sync_out = synchronized_second_output;
		if (!comparator_two_control_second[`BIT_SECOND_OUTPUT_SYNC_ENABLE]) begin
			next_sync_out = second_comparator_output;
		end else if (timer_fall) begin
			next_sync_out = second_comparator_output;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			timer_clock_d <= 1'b0;
			synchronized_second_output <= 1'b0;
		end else begin
			timer_clock_d <= timer_clock;
			synchronized_second_output <= next_sync_out;
		end
	end

	// registered outputs: port routing, reference selects, gate
	always @(posedge clk) begin
		if (!nrst) begin
			first_port_out <= 1'b0;
			second_port_out <= 1'b0;
			first_reference_input <= 1'b0;
			second_reference_input <= 1'b0;
			timer_gate_from_comparator <= 1'b0;
		end else begin
			first_port_out <= sel_first;
			second_port_out <= sel_second;
			first_reference_input <= comparator_two_control_second[`BIT_FIRST_REFERENCE_SELECT];
			second_reference_input <= comparator_two_control_second[`BIT_SECOND_REFERENCE_SELECT];
			timer_gate_from_comparator <= ~comparator_two_control_second[`BIT_TIMER_GATE_SOURCE_SELECT];
		end
	end
endmodule

/* File: src/comparator_latch_defines.vh */
// register offsets, field positions, reset values for the comparator latch block
`ifndef COMPARATOR_LATCH_DEFINES_VH
`define COMPARATOR_LATCH_DEFINES_VH
`define ADDR_COMPARATOR_TWO_CONTROL_SECOND 4'h0
`define ADDR_LATCH_CONTROL_REGISTER 4'h4
`define ADDR_LATCH_STATUS 4'h8
`define BIT_FIRST_OUTPUT_MIRROR 7
`define BIT_SECOND_OUTPUT_MIRROR 6
`define BIT_FIRST_REFERENCE_SELECT 5
`define BIT_SECOND_REFERENCE_SELECT 4
`define BIT_TIMER_GATE_SOURCE_SELECT 1
`define BIT_SECOND_OUTPUT_SYNC_ENABLE 0
`define BIT_LATCH_CONFIG_HI 7
`define BIT_LATCH_CONFIG_LO 6
`define BIT_SOFTWARE_SET_PULSE 3
`define BIT_SOFTWARE_RESET_PULSE 2
`define CTRL2_WRITE_MASK 8'h33
`define CTRL2_RESET 8'h02
`define LATCH_CTRL_WRITE_MASK 8'hc0
`define LATCH_CTRL_RESET 8'h00
`endif

/* File: src/sr_storage.v */
// reset-dominant set/reset storage element, clocked model
`timescale 1ns/1ps
module sr_storage (
	input wire clk,
	input wire nrst,
	input wire set_in,
	input wire reset_in,
	output reg q
);
	// reset wins over set; low inputs hold state
	always @(posedge clk) begin
		if (!nrst) begin
			q <= 1'b0;
		end else if (reset_in) begin
			q <= 1'b0;
		end else if (set_in) begin
			q <= 1'b1;
		end
	end
endmodule

/* File: src/output_select.v */
// output selector: comparator outputs or latch outputs per configuration
`timescale 1ns/1ps
module output_select (
	input wire [1:0] config_sel,
	input wire first_comparator_output,
	input wire second_comparator_output,
	input wire latch_q,
	output wire first_port_out,
	output wire second_port_out
);
	// bit 0 steers the first pin to q, bit 1 steers the second pin to not q
	assign first_port_out = config_sel[0] ? latch_q : first_comparator_output;
	assign second_port_out = config_sel[1] ? ~latch_q : second_comparator_output;
endmodule

/* File: verification/comparator_partner.sv */
// model of the two comparators and the prescaled timer clock
`timescale 1ns/1ps
module comparator_partner (
	output logic cmp1,
	output logic cmp2,
	output logic tclk
);
	// levels only move when asked, just after an edge; timer clock stands still between asks
	initial begin
		cmp1 = 1'b0;
		cmp2 = 1'b0;
		tclk = 1'b0;
	end
	task automatic drive(input logic a, input logic b, input logic t);
		cmp1 <= a;
		cmp2 <= b;
		tclk <= t;
	endtask
endmodule

/* File: verification/comparator_sr_latch_ctrl_checker.sv */
// port assertions for the comparator latch block
`timescale 1ns/1ps
module comparator_sr_latch_ctrl_checker (
	input wire clk,
	input wire nrst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire first_comparator_output,
	input wire second_comparator_output,
	input wire first_port_out,
	input wire second_port_out,
	input wire first_reference_input,
	input wire second_reference_input,
	input wire timer_gate_from_comparator
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [1:0] cfg;
	wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	// shadow of the output configuration, so port checks know the mode
	always @(posedge clk) begin
		if (!nrst)
			cfg <= 2'h0;
		else if (wr && wb_adr_i == 4'h4)
			cfg <= wb_dat_i[7:6];
	end
	sequence ctrl_wr;
		wr && wb_adr_i == 4'h0;
	endsequence
	// no pulse can be in flight when the bus was idle for three cycles
	sequence quiet;
		!wb_cyc_i && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2);
	endsequence
	ref_one_a: assert property (ctrl_wr |-> ##2 first_reference_input == $past(wb_dat_i[5], 2))
		else $error("first reference select wrong");
	ref_two_a: assert property (ctrl_wr |-> ##2 second_reference_input == $past(wb_dat_i[4], 2))
		else $error("second reference select wrong");
	gate_src_a: assert property (ctrl_wr |-> ##2 timer_gate_from_comparator == !$past(wb_dat_i[1], 2))
		else $error("gate source wrong");
	direct_pass_a: assert property ($past(cfg) == 2'h0 |-> {first_port_out, second_port_out} ==
		$past({first_comparator_output, second_comparator_output})) else $error("direct path wrong");
	latch_set_a: assert property (cfg[0] && first_comparator_output && !second_comparator_output ##0 quiet
		|-> ##2 (!cfg[0] || first_port_out)) else $error("latch did not set");
	reset_wins_a: assert property (cfg[0] && second_comparator_output |-> ##2 (!cfg[0] || !first_port_out))
		else $error("latch did not reset");
	latch_hold_a: assert property (cfg[0] && $past(!first_comparator_output && !second_comparator_output) ##0 quiet
		|=> (!cfg[0] || $stable(first_port_out))) else $error("latch moved without input");
	inverse_pin_a: assert property ($past(cfg) == 2'h3 |-> second_port_out != first_port_out)
		else $error("pins not complementary");
endmodule
bind comparator_sr_latch_ctrl comparator_sr_latch_ctrl_checker chk (.*);

/* File: verification/tb_top.sv */
// self-checking bench for the comparator latch block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dati = 32'h0;
	logic [31:0] dato;
	logic [31:0] rd;
	logic ack, c1, c2, tclk, p1, p2, r1, r2, gate, sync;
	integer n_errors = 0;
	integer n_compared = 0;
	integer cycles = 0;
	always #5 clk = ~clk;
	comparator_partner partner (.cmp1(c1), .cmp2(c2), .tclk(tclk));
	comparator_sr_latch_ctrl DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dati), .wb_dat_o(dato), .wb_ack_o(ack),
		.first_comparator_output(c1), .second_comparator_output(c2), .timer_clock(tclk), .first_port_out(p1),
		.second_port_out(p2), .first_reference_input(r1), .second_reference_input(r2),
		.timer_gate_from_comparator(gate), .synchronized_second_output(sync));
	task automatic close_out();
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; the hang guard below ends a missing ack
	task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dati <= d;
		@(posedge clk);
		while (ack !== 1'b1)
			@(posedge clk);
		rd = dato;
		cyc <= 1'b0;
		@(posedge clk);
	endtask
	task automatic pulse(input logic a, input logic b);
		partner.drive(a, b, 1'b0);
		@(posedge clk);
		partner.drive(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clk);
	endtask
	task automatic t_regs();
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'h02);
		partner.drive(1'b1, 1'b0, 1'b0);
		bus(1'b1, 4'h0, 4'h1, 32'hff);
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'hb3);
		check({r1, r2, gate, p1, p2}, 5'b11010);
		bus(1'b1, 4'h0, 4'h0, 32'h00);
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'hb3);
		bus(1'b1, 4'h0, 4'h1, 32'h0c);
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'h80);
		check({r1, r2, gate}, 3'b001);
		bus(1'b0, 4'hc, 4'h1, 32'h0);
		check(rd, 32'h0);
		pulse(1'b0, 1'b0);
	endtask
	task automatic t_latch();
		bus(1'b1, 4'h4, 4'h1, 32'h40);
		// latch is set from the register scenario, so each step below really moves it
		pulse(1'b1, 1'b1);
		check(p1, 1'b0);
		pulse(1'b1, 1'b0);
		check(p1, 1'b1);
		bus(1'b1, 4'h4, 4'h1, 32'h44);
		bus(1'b0, 4'h8, 4'h1, 32'h0);
		check(rd, 32'h0);
		bus(1'b1, 4'h4, 4'h1, 32'h48);
		bus(1'b0, 4'h4, 4'h1, 32'h0);
		check(rd, 32'h40);
		check(p1, 1'b1);
		// a stuck set pulse would bring the latch back once the reset input drops
		pulse(1'b0, 1'b1);
		check(p1, 1'b0);
		bus(1'b1, 4'h4, 4'h1, 32'hc0);
		pulse(1'b1, 1'b0);
		check({p1, p2}, 2'b10);
		bus(1'b1, 4'h4, 4'h1, 32'h84);
		repeat (2) @(posedge clk);
		check({p1, p2}, 2'b01);
	endtask
	task automatic t_sync();
		bus(1'b1, 4'h0, 4'h1, 32'h01);
		partner.drive(1'b0, 1'b1, 1'b1);
		repeat (4) @(posedge clk);
		check(sync, 1'b0);
		check(gate, 1'b1);
		partner.drive(1'b0, 1'b1, 1'b0);
		repeat (4) @(posedge clk);
		check(sync, 1'b1);
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'h41);
		// sync off: output follows the comparator with no timer clock fall
		bus(1'b1, 4'h0, 4'h1, 32'h00);
		partner.drive(1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge clk);
		check(sync, 1'b0);
	endtask
	// mid-run reset with quiet comparators; everything must come back to its reset state
	task automatic t_reset();
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		check({p1, p2, r1, r2, gate, sync}, 6'h00);
		bus(1'b0, 4'h0, 4'h1, 32'h0);
		check(rd, 32'h02);
		bus(1'b0, 4'h4, 4'h1, 32'h0);
		check(rd, 32'h00);
		bus(1'b0, 4'h8, 4'h1, 32'h0);
		check(rd, 32'h00);
	endtask
	// hang guard, far above the roughly 110 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_latch();
		t_sync();
		t_reset();
		close_out();
	end
endmodule
